// ==== core/urp_port_ctrl.sv ====
/*
 * Upper half (bits 15:6) of the root port status and control register
 * with suspend, overcurrent, port reset, speed detect and resume logic.
 * Assumes word writes arrive as a one-cycle strobe on the system clock,
 * the lower half supplies enable and connect status, and pins are async.
 */
`timescale 1ns/1ps
`default_nettype none
module urp_port_ctrl (
	// Clock and reset
	input  wire logic        clk_sys,
	input  wire logic        rstn,
	// Register access, word writes only
	input  wire logic        regWrStb,
	input  wire logic [15:0] regWrData,
	output logic      [15:0] regRdData,
	// Host controller side
	input  wire logic        globalSuspend,
	input  wire logic        portEnabledIn,
	input  wire logic        connectStatus,
	input  wire logic        xferActive,
	// Port status toward the lower half and scheduler
	output logic      [1:0]  portState,
	output logic             portDisableReq,
	output logic             blockDownstream,
	// Overcurrent pin, active low
	input  wire logic        overcurrentPinN,
	// Downstream line
	input  wire logic        lineDpIn,
	input  wire logic        lineDmIn,
	output logic             lineDpOut,
	output logic             lineDmOut,
	output logic             lineOutEnN
);

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers

	logic       ocPinSync;
	logic [1:0] lineSync;
	logic       lineDp;
	logic       lineDm;

	urp_sync #(
		.WIDTH (1),
		.INIT  (1'b1)
	) u_oc_sync (
		.clk_sys (clk_sys),
		.rstn    (rstn),
		.asyncIn (overcurrentPinN),
		.syncOut (ocPinSync)
	);

	urp_sync #(
		.WIDTH (2),
		.INIT  (2'h0)
	) u_line_sync (
		.clk_sys (clk_sys),
		.rstn    (rstn),
		.asyncIn ({lineDmIn, lineDpIn}),
		.syncOut (lineSync)
	);

	assign lineDp = lineSync[0];
	assign lineDm = lineSync[1];

	////////////////////////////////////////////////////////////////////////
	// Write decode

	logic wrSuspend;
	logic wrOcClear;
	logic wrPortReset;
	logic wrResume;

	assign wrSuspend   = regWrData[urp_pkg::SUSPEND_BIT];
	assign wrOcClear   = regWrStb & regWrData[urp_pkg::OC_CHANGE_BIT];
	assign wrPortReset = regWrData[urp_pkg::PORT_RST_BIT];
	assign wrResume    = regWrData[urp_pkg::RESUME_BIT];

	////////////////////////////////////////////////////////////////////////
	// Overcurrent

	logic ocPinPrev_reg;
	logic ocChange_reg;
	logic ocActive;
	logic ocFall;

	assign ocActive = ~ocPinSync;
	assign ocFall   = ocPinPrev_reg & ~ocPinSync;

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			ocPinPrev_reg <= 1'b1;
		end else begin
			ocPinPrev_reg <= ocPinSync;
		end
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			ocChange_reg <= 1'b0;
		end else if (ocFall) begin
			ocChange_reg <= 1'b1;
		end else if (wrOcClear) begin
			ocChange_reg <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Port reset

	logic portReset_reg;

	// Held only as long as software keeps it
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			portReset_reg <= 1'b0;
		end else if (regWrStb) begin
			portReset_reg <= wrPortReset;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Suspend

	logic suspendReq_reg;
	logic suspended_reg;

	// Software is trusted not to request this under global suspend
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			suspendReq_reg <= 1'b0;
		end else if (regWrStb) begin
			suspendReq_reg <= wrSuspend;
		end
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			suspended_reg <= 1'b0;
		end else if (regWrStb && !wrSuspend) begin
			suspended_reg <= 1'b0;
		end else if (suspendReq_reg && !xferActive) begin
			suspended_reg <= 1'b1;
		end
	end

	assign blockDownstream = suspended_reg & ~portReset_reg;

	assign portState = portEnabledIn ?
		(suspended_reg ? urp_pkg::PSTATE_SUSPENDED : urp_pkg::PSTATE_ENABLED) :
		urp_pkg::PSTATE_DISABLED;

	assign portDisableReq = ocActive | portReset_reg;

	////////////////////////////////////////////////////////////////////////
	// Line state and speed detect

	logic lowSpeed_reg;
	logic lineJ;
	logic lineK;
	logic lineJPrev_reg;
	logic driving;

	assign lineJ = lowSpeed_reg ? (lineDm & ~lineDp) : (lineDp & ~lineDm);
	assign lineK = lowSpeed_reg ? (lineDp & ~lineDm) : (lineDm & ~lineDp);

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			lowSpeed_reg <= 1'b0;
		end else if (!connectStatus) begin
			lowSpeed_reg <= 1'b0;
		end else if (!xferActive && !driving && !suspended_reg && (lineDp ^ lineDm)) begin
			lowSpeed_reg <= lineDm;
		end
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			lineJPrev_reg <= 1'b0;
		end else begin
			lineJPrev_reg <= lineJ;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Resume

	logic resume_reg;
	logic resumeSeen;
	logic eopStart;
	logic eopBusy;
	logic eopDone;
	logic eopSe0;
	logic eopJ;
	logic driveK;

	// J-to-K while suspended; own drive masked
	assign resumeSeen = suspended_reg & ~driving & lineJPrev_reg & lineK;
	assign eopStart   = regWrStb & ~wrResume & resume_reg & ~eopBusy;

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			resume_reg <= 1'b0;
		end else if (resumeSeen) begin
			resume_reg <= 1'b1;
		end else if (regWrStb && wrResume) begin
			resume_reg <= 1'b1;
		end else if (eopDone) begin
			resume_reg <= 1'b0;
		end
	end

	urp_eop_gen u_eop_gen (
		.clk_sys  (clk_sys),
		.rstn     (rstn),
		.start    (eopStart),
		.busy     (eopBusy),
		.done     (eopDone),
		.driveSe0 (eopSe0),
		.driveJ   (eopJ)
	);

	// K while resume and suspended
	// Not in the done cycle: a late K would read back as a fresh resume
	assign driveK  = resume_reg & suspended_reg & ~eopBusy & ~eopStart & ~eopDone;
	assign driving = portReset_reg | eopBusy | driveK;

	////////////////////////////////////////////////////////////////////////
	// Line drivers; reset beats EOP beats resume K

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			lineDpOut  <= 1'b0;
			lineDmOut  <= 1'b0;
			lineOutEnN <= 1'b1;
		end else if (portReset_reg || eopSe0) begin
			lineDpOut  <= 1'b0;
			lineDmOut  <= 1'b0;
			lineOutEnN <= 1'b0;
		end else if (eopJ) begin
			lineDpOut  <= ~lowSpeed_reg;
			lineDmOut  <= lowSpeed_reg;
			lineOutEnN <= 1'b0;
		end else if (driveK) begin
			lineDpOut  <= lowSpeed_reg;
			lineDmOut  <= ~lowSpeed_reg;
			lineOutEnN <= 1'b0;
		end else begin
			lineDpOut  <= 1'b0;
			lineDmOut  <= 1'b0;
			lineOutEnN <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read data; bits 5:0 belong to the lower half and read zero here

	logic unusedGlobalSuspend;
	assign unusedGlobalSuspend = globalSuspend;

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			regRdData <= urp_pkg::PORT_STATUS_CONTROL_RESET;
		end else begin
			regRdData <= '0;
			regRdData[urp_pkg::SUSPEND_BIT]   <= suspended_reg;
			regRdData[urp_pkg::OC_CHANGE_BIT] <= ocChange_reg;
			regRdData[urp_pkg::OC_IND_BIT]    <= ocActive;
			regRdData[urp_pkg::PORT_RST_BIT]  <= portReset_reg;
			regRdData[urp_pkg::LOW_SPEED_BIT] <= lowSpeed_reg;
			regRdData[urp_pkg::RSVD_ONE_BIT]  <= 1'b1;
			regRdData[urp_pkg::RESUME_BIT]    <= resume_reg;
		end
	end

endmodule : urp_port_ctrl
`default_nettype wire

// ==== core/urp_pkg.sv ====
/*
 * Constants, states and timing for the upper half of a root port
 * status and control register (bits 15:6).
 * Assumes a single 20 MHz system clock; lower register bits live elsewhere.
 */
// Operation
// - Suspended port blocks downstream data except resets, and watches for resume.
// - Suspend blocking starts only after an ongoing transaction ends.
// - Suspend bit reads one only once the port is really suspended.
// - Falling edge on overcurrent pin sets the overcurrent change flag.
// - Writing one to the overcurrent change flag clears it.
// - Overcurrent bit reads one while the pin is low.
// - Port is disabled while overcurrent is indicated.
// - Port reset bit holds port disabled and drives reset signalling.
// - Low speed bit is read only, one for a low speed device.
// - Bit 7 always reads one.
// - Writing one to resume detect starts resume signalling.
// - J-to-K transition on a suspended port sets resume detect.
// - K-state is driven while resume detect is one and port suspended.
// - Clearing resume detect sends low speed EOP; bit reads one until done.
// - Only software enables a port; hardware may disable it on faults.
package urp_pkg;

	////////////////////////////////////////////////////////////////////////
	// Register field positions
	localparam int REG_W         = 16;
	localparam int RSVD_HI_BIT   = 15;
	localparam int RSVD_LO_BIT   = 13;
	localparam int SUSPEND_BIT   = 12;
	localparam int OC_CHANGE_BIT = 11;
	localparam int OC_IND_BIT    = 10;
	localparam int PORT_RST_BIT  = 9;
	localparam int LOW_SPEED_BIT = 8;
	localparam int RSVD_ONE_BIT  = 7;
	localparam int RESUME_BIT    = 6;

	localparam logic [15:0] PORT_STATUS_CONTROL_RESET = 16'h0080;

	////////////////////////////////////////////////////////////////////////
	// Port state encoding {suspend, enable}
	localparam logic [1:0] PSTATE_DISABLED  = 2'h0;
	localparam logic [1:0] PSTATE_ENABLED   = 2'h1;
	localparam logic [1:0] PSTATE_SUSPENDED = 2'h3;

	////////////////////////////////////////////////////////////////////////
	// Timing
	localparam int CLK_MHZ   = 20;
	// Low speed bit time in ns, 1 / 1.5 MHz rounded up
	localparam int LS_BIT_NS = 667;
	localparam int EOP_SE0_NS = 2 * LS_BIT_NS;
	localparam int EOP_J_NS   = LS_BIT_NS;
	localparam int CNT_W      = 6;
	// Least times: round up to whole cycles
	localparam logic [CNT_W-1:0] EOP_SE0_CYC = CNT_W'((EOP_SE0_NS * CLK_MHZ + 999) / 1000);
	localparam logic [CNT_W-1:0] EOP_J_CYC   = CNT_W'((EOP_J_NS * CLK_MHZ + 999) / 1000);

	typedef enum logic [1:0] {
		EOP_IDLE,
		EOP_SE0,
		EOP_J
	} urp_eop_state_t;

endpackage : urp_pkg

// ==== core/urp_sync.sv ====
/*
 * Two flip-flop synchroniser for pin levels.
 * Assumes inputs are asynchronous levels; first stage feeds only the second.
 */
`timescale 1ns/1ps
`default_nettype none
module urp_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] INIT = '0
) (
	// Clock and reset
	input  wire logic             clk_sys,
	input  wire logic             rstn,
	// Data
	input  wire logic [WIDTH-1:0] asyncIn,
	output logic      [WIDTH-1:0] syncOut
);

	logic [WIDTH-1:0] stage1_reg;

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			stage1_reg <= INIT;
			syncOut    <= INIT;
		end else begin
			stage1_reg <= asyncIn;
			syncOut    <= stage1_reg;
		end
	end

endmodule : urp_sync
`default_nettype wire

// ==== core/urp_eop_gen.sv ====
/*
 * Low speed end-of-packet sequencer: SE0 for two bit times, then J for one.
 * Assumes a one-cycle start pulse, ignored while busy.
 */
`timescale 1ns/1ps
`default_nettype none
module urp_eop_gen (
	// Clock and reset
	input  wire logic clk_sys,
	input  wire logic rstn,
	// Control
	input  wire logic start,
	output logic      busy,
	output logic      done,
	// Line phases
	output logic      driveSe0,
	output logic      driveJ
);

	urp_pkg::urp_eop_state_t         state_reg;
	logic [urp_pkg::CNT_W-1:0]       count_reg;

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			state_reg <= urp_pkg::EOP_IDLE;
			count_reg <= '0;
			done      <= 1'b0;
		end else begin
			done <= 1'b0;
			case (state_reg)
				urp_pkg::EOP_IDLE: begin
					if (start) begin
						state_reg <= urp_pkg::EOP_SE0;
						count_reg <= urp_pkg::EOP_SE0_CYC - 1'b1;
					end
				end
				urp_pkg::EOP_SE0: begin
					if (count_reg == '0) begin
						state_reg <= urp_pkg::EOP_J;
						count_reg <= urp_pkg::EOP_J_CYC - 1'b1;
					end else begin
						count_reg <= count_reg - 1'b1;
					end
				end
				urp_pkg::EOP_J: begin
					if (count_reg == '0) begin
						state_reg <= urp_pkg::EOP_IDLE;
						done      <= 1'b1;
					end else begin
						count_reg <= count_reg - 1'b1;
					end
				end
				default: begin
					state_reg <= urp_pkg::EOP_IDLE;
				end
			endcase
		end
	end

	assign busy     = (state_reg != urp_pkg::EOP_IDLE);
	assign driveSe0 = (state_reg == urp_pkg::EOP_SE0);
	assign driveJ   = (state_reg == urp_pkg::EOP_J);

endmodule : urp_eop_gen
`default_nettype wire

// ==== tb/urp_port_ctrl_sva.sv ====
/* Assertions on the ports of urp_port_ctrl.
   Assumes binding to every instance of urp_port_ctrl. */
`timescale 1ns/1ps
`default_nettype none
module urp_port_ctrl_chk (
	// Clock and reset
	input wire logic        clk_sys,
	input wire logic        rstn,
	// Register
	input wire logic        regWrStb,
	input wire logic [15:0] regWrData,
	input wire logic [15:0] regRdData,
	// Port control
	input wire logic        xferActive,
	input wire logic        portEnabledIn,
	input wire logic [1:0]  portState,
	input wire logic        portDisableReq,
	input wire logic        blockDownstream,
	// Line drive
	input wire logic        lineDpOut,
	input wire logic        lineDmOut,
	input wire logic        lineOutEnN
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rstn);

	a_fixed_bits: assert property (regRdData[15:13] == 3'h0 && regRdData[7] && regRdData[5:0] == 6'h0)
		else $error("fixed bits wrong");
	a_oc_flag: assert property ($rose(regRdData[10]) |-> ##[0:2] regRdData[11])
		else $error("oc flag not set");
	a_oc_disable: assert property ($rose(regRdData[10]) |-> $past(portDisableReq))
		else $error("oc without disable");
	a_reset_se0: assert property (regRdData[9] |-> !lineOutEnN && !lineDpOut && !lineDmOut)
		else $error("no reset signalling");
	a_reset_disable: assert property (regWrStb && regWrData[9] |=> portDisableReq)
		else $error("reset not disabling");
	a_state_map: assert property (portState[0] == portEnabledIn && portState != 2'h2)
		else $error("bad port state");
	a_block_suspend: assert property (blockDownstream |-> portState == urp_pkg::PSTATE_SUSPENDED)
		else $error("block outside suspend");
	a_suspend_wait: assert property (!portState[1] && xferActive |=> !portState[1])
		else $error("suspend during transfer");
	a_suspend_read: assert property ($rose(regRdData[12]) |-> $past(portState[1]))
		else $error("suspend bit early");
	a_resume_drive: assert property (
		regWrStb && regWrData[6] && portState[1] |-> ##[1:3] !lineOutEnN && (lineDpOut ^ lineDmOut))
		else $error("no resume drive");
	a_eop_se0: assert property (
		regWrStb && !regWrData[6] && regRdData[6] && !regRdData[9]
		|-> ##[1:4] (!lineOutEnN && !lineDpOut && !lineDmOut)[*8])
		else $error("no eop");
endmodule : urp_port_ctrl_chk

bind urp_port_ctrl urp_port_ctrl_chk u_chk (
	.clk_sys(clk_sys),
	.rstn(rstn),
	.regWrStb(regWrStb),
	.regWrData(regWrData),
	.regRdData(regRdData),
	.xferActive(xferActive),
	.portEnabledIn(portEnabledIn),
	.portState(portState),
	.portDisableReq(portDisableReq),
	.blockDownstream(blockDownstream),
	.lineDpOut(lineDpOut),
	.lineDmOut(lineDmOut),
	.lineOutEnN(lineOutEnN)
);
`default_nettype wire

// ==== tb/urp_usb_dev.sv ====
/* Device on the root port: idle J at its speed, K while waking.
   Assumes the host drive wins whenever its enable is low. */
`timescale 1ns/1ps
`default_nettype none
module urp_usb_dev (
	// Device setup
	input  wire logic lowSpeed,
	input  wire logic wakeReq,
	// Host drive
	input  wire logic lineDpOut,
	input  wire logic lineDmOut,
	input  wire logic lineOutEnN,
	// Wire levels
	output logic      lineDpIn,
	output logic      lineDmIn
);
	logic devDp;
	// Pull-up side sets J; K is its inverse
	assign devDp = lowSpeed ^ ~wakeReq;
	assign lineDpIn = lineOutEnN ? devDp : lineDpOut;
	assign lineDmIn = lineOutEnN ? ~devDp : lineDmOut;
endmodule : urp_usb_dev
`default_nettype wire

// ==== tb/test_urp_port_ctrl.sv ====
/* Bench for urp_port_ctrl with a device model on the line.
   Assumes design files and urp_usb_dev compile first. */
`timescale 1ns/1ps
`default_nettype none
module test_urp_port_ctrl;
	typedef struct packed {
		logic [15:0] wr;
		logic [15:0] rd;
		logic        dis;
	} urp_row_t;
	logic        clk_sys, rstn, regWrStb, xferActive, portDisableReq, blockDownstream;
	logic        overcurrentPinN, lineDpIn, lineDmIn, lineDpOut, lineDmOut, lineOutEnN;
	logic        portEnabledIn, lowSpeed, wakeReq, connected;
	logic [1:0]  portState;
	logic [15:0] regWrData, regRdData;
	int          failures, check_count, n, eopCyc;
	urp_row_t    rows [4] = '{'{16'h0500, 16'h0080, 1'b0}, '{16'h0800, 16'h0080, 1'b0},
		'{16'h0200, 16'h0280, 1'b1}, '{16'h0000, 16'h0080, 1'b0}};

	////////////////////////////////////////
	initial begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end

	urp_port_ctrl uut (.clk_sys(clk_sys), .rstn(rstn), .regWrStb(regWrStb), .regWrData(regWrData),
		.regRdData(regRdData), .globalSuspend(1'b0), .portEnabledIn(portEnabledIn), .connectStatus(connected),
		.xferActive(xferActive), .portState(portState), .portDisableReq(portDisableReq),
		.blockDownstream(blockDownstream), .overcurrentPinN(overcurrentPinN), .lineDpIn(lineDpIn),
		.lineDmIn(lineDmIn), .lineDpOut(lineDpOut), .lineDmOut(lineDmOut), .lineOutEnN(lineOutEnN));
	urp_usb_dev dev (.lowSpeed(lowSpeed), .wakeReq(wakeReq), .lineDpOut(lineDpOut),
		.lineDmOut(lineDmOut), .lineOutEnN(lineOutEnN), .lineDpIn(lineDpIn), .lineDmIn(lineDmIn));

	////////////////////////////////////////
	task automatic cyc(input int k);
		repeat (k) @(negedge clk_sys);
	endtask : cyc

	task automatic wr(input logic [15:0] d);
		regWrStb = 1'b1;
		regWrData = d;
		cyc(1);
		regWrStb = 1'b0;
	endtask : wr

	task automatic chk(input bit ok, input string m);
		check_count++;
		if (!ok) begin
			failures++;
			$display("[ERR] %0t %s", $time, m);
		end
	endtask : chk

	task automatic conclude;
		$display("checks %0d mismatches %0d", check_count, failures);
		if (failures == 0 && check_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : conclude

	// Bounded wait for the resume bit to drop
	task automatic waitClr(output int c);
		c = 0;
		while (regRdData[6] !== 1'b0 && c < 100) begin
			cyc(1);
			c++;
		end
		if (c == 100) begin
			failures++;
			conclude();
		end
	endtask : waitClr

	////////////////////////////////////////
	initial begin
		{rstn, regWrStb, xferActive, lowSpeed, wakeReq} = 5'h00;
		regWrData = 16'h0000;
		portEnabledIn = 1'b1;
		connected = 1'b1;
		overcurrentPinN = 1'b1;
		failures = 0;
		check_count = 0;
		eopCyc = urp_pkg::EOP_SE0_CYC + urp_pkg::EOP_J_CYC;
		cyc(12);
		rstn = 1'b1;
		cyc(4);
		chk(regRdData === 16'h0080 && portState === urp_pkg::PSTATE_ENABLED, "reset value");
		foreach (rows[i]) begin
			wr(rows[i].wr);
			cyc(3);
			chk(regRdData === rows[i].rd && portDisableReq === rows[i].dis, "row");
		end
		$display("table done");
		overcurrentPinN = 1'b0;
		cyc(6);
		chk(regRdData[11:10] === 2'h3 && portDisableReq === 1'b1, "oc set");
		wr(16'h0800);
		cyc(3);
		chk(regRdData[11:10] === 2'h1, "oc clear");
		overcurrentPinN = 1'b1;
		cyc(6);
		chk(regRdData === 16'h0080 && portDisableReq === 1'b0, "oc gone");
		overcurrentPinN = 1'b0;
		cyc(2);
		// Clear strobe meets the edge that sees the synced fall
		wr(16'h0800);
		cyc(3);
		chk(regRdData[11:10] === 2'h3, "oc set lost to clear");
		overcurrentPinN = 1'b1;
		wr(16'h0800);
		cyc(6);
		chk(regRdData === 16'h0080 && portDisableReq === 1'b0, "oc flag stuck");
		$display("overcurrent done");
		xferActive = 1'b1;
		wr(16'h1000);
		cyc(4);
		chk(regRdData[12] === 1'b0 && blockDownstream === 1'b0, "early suspend");
		xferActive = 1'b0;
		cyc(4);
		chk(regRdData[12] === 1'b1 && blockDownstream === 1'b1, "suspend");
		wakeReq = 1'b1;
		cyc(8);
		wakeReq = 1'b0;
		chk(regRdData[6] === 1'b1 && {lineOutEnN, lineDpOut, lineDmOut} === 3'h1, "wake");
		wr(16'h1000);
		waitClr(n);
		chk(n > eopCyc && n <= eopCyc + 3 && regRdData[12] === 1'b1, "eop length");
		cyc(2);
		wr(16'h1040);
		cyc(3);
		chk({lineOutEnN, lineDpOut, lineDmOut} === 3'h1, "resume drive");
		wr(16'h1000);
		waitClr(n);
		// Long enough to see a resume re-detected from the own line drive
		cyc(6);
		chk(lineOutEnN === 1'b1 && regRdData[6] === 1'b0, "drive left on");
		wr(16'h1200);
		cyc(3);
		chk(blockDownstream === 1'b0 && {lineOutEnN, lineDpOut, lineDmOut} === 3'h0, "reset in suspend");
		wr(16'h0000);
		cyc(3);
		chk(portState === urp_pkg::PSTATE_ENABLED && regRdData === 16'h0080, "awake");
		$display("suspend done");
		lowSpeed = 1'b1;
		cyc(6);
		wr(16'h0000);
		cyc(3);
		chk(regRdData === 16'h0180, "low speed");
		connected = 1'b0;
		cyc(3);
		chk(regRdData[8] === 1'b0, "speed kept on disconnect");
		connected = 1'b1;
		portEnabledIn = 1'b0;
		cyc(1);
		chk(portState === urp_pkg::PSTATE_DISABLED, "disabled state");
		portEnabledIn = 1'b1;
		cyc(6);
		rstn = 1'b0;
		cyc(2);
		chk(regRdData === 16'h0080 && lineOutEnN === 1'b1, "mid reset");
		rstn = 1'b1;
		cyc(6);
		chk(regRdData === 16'h0180 && portState === urp_pkg::PSTATE_ENABLED, "after reset");
		$display("reset done");
		conclude();
	end
endmodule : test_urp_port_ctrl
`default_nettype wire
